// ==== verilog/vsc_pkg.sv ====
// Package with constants for the video serial channel slave
package vsc_pkg;
    localparam int HDR_BYTES = 4;
    localparam int RAW_PAYLOAD_BYTES = 160;
    localparam int RGB_PAYLOAD_BYTES = 240;
    localparam int RAW_PKT_BYTES = HDR_BYTES + RAW_PAYLOAD_BYTES;
    localparam int RGB_PKT_BYTES = HDR_BYTES + RGB_PAYLOAD_BYTES;
    localparam int LINES_PER_FRAME = 60;
    localparam logic [7:0] RST_SHIFT = 8'hFF;
    localparam logic [3:0] DISCARD_NIBBLE = 4'hF;
    localparam logic [7:0] DISCARD_FILL = 8'h00;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [11:0] LINE_ZERO = 12'h000;
    localparam logic [1:0] SYNC_ZERO = 2'h0;
    typedef enum logic {FMT_RAW14, FMT_RGB888} vsc_fmt_e;
endpackage

// ==== verilog/vsc_slave.sv ====
// Video serial channel slave: packet output over a mode 3 serial link
// Overview of operation
// - Video leaves only as packets on the data line, with no strobes.
// - No flow control: the slave never asks the master to wait.
// - Bits are served at any master rate slow enough for CLOCK to sample each edge.
// - Slow spread-out and fast burst clocks both work.
// - With no frame ready, a clocking master gets discard packets.
// - Clock idles high, data changes on falling edges, MSB first.
// - Each packet has a 2-byte id, 2-byte check and 160/240 payload.
// - Discard packets carry an id whose second nibble is all ones.
`timescale 1ns/1ps
module vsc_slave
    import vsc_pkg::*;
#(
    parameter int LINES = vsc_pkg::LINES_PER_FRAME
) (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RST,
    // Serial link pins
    input wire logic SCK,
    input wire logic CS_N,
    output logic MISO,
    output logic MISO_OE_N,
    // Video source: one line at a time
    input wire vsc_pkg::vsc_fmt_e FORMAT,
    input wire logic FRAME_READY,
    output logic FRAME_TAKE,
    output logic [11:0] LINE_NUM,
    output logic [7:0] BYTE_IDX,
    input wire logic [7:0] PIXEL_BYTE,
    input wire logic [15:0] LINE_CRC
);
    import vsc_pkg::*;

    logic [1:0] sck_sync_q;
    logic [1:0] cs_sync_q;
    logic sck_prev_q;
    logic sck_fall;
    logic sck_rise;
    logic cs_act;

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            sck_sync_q <= 2'b11;
            cs_sync_q <= 2'b11;
            sck_prev_q <= 1'b1;
        end else begin
            sck_sync_q <= {sck_sync_q[0], SCK};
            cs_sync_q <= {cs_sync_q[0], CS_N};
            sck_prev_q <= sck_sync_q[1];
        end
    end

    // Edges found by sampling, so any master rate up to the limit works
    assign sck_fall = sck_prev_q & ~sck_sync_q[1];
    assign sck_rise = ~sck_prev_q & sck_sync_q[1];
    assign cs_act = ~cs_sync_q[1];

    logic [2:0] bit_q;
    logic [7:0] byte_q;
    logic [7:0] shift_q;
    logic discard_q;
    logic [11:0] line_q;
    logic started_q;
    logic take_q;
    logic [7:0] pkt_last;
    logic [7:0] next_byte;
    logic [7:0] nbyte;
    logic end_pkt;

    assign pkt_last = (FORMAT == FMT_RGB888) ? 8'(RGB_PKT_BYTES - 1)
                                             : 8'(RAW_PKT_BYTES - 1);
    assign end_pkt = (byte_q == pkt_last) && (bit_q == BIT_LAST);
    assign nbyte = end_pkt ? BYTE_ZERO : byte_q + 8'h01;

    logic disc_d;
    logic [11:0] line_d;

    // Frame state after a packet end, so the next id byte is the right kind
    always_comb begin
        disc_d = discard_q;
        line_d = line_q;
        if (end_pkt) begin
            if (!discard_q && line_q == 12'(LINES - 1)) begin
                disc_d = 1'b1;
                line_d = LINE_ZERO;
            end else if (!discard_q) begin
                line_d = line_q + 12'h001;
            end else if (FRAME_READY) begin
                disc_d = 1'b0;
            end
        end
    end

    function automatic logic [7:0] pick(input logic [7:0] idx,
                                        input logic disc,
                                        input logic [11:0] ln);
        logic [7:0] r;
        r = DISCARD_FILL;
        if (disc) begin
            if (idx == 8'h00) r = {4'h0, DISCARD_NIBBLE};
        end else begin
            unique case (idx)
                8'h00: r = {4'h0, ln[11:8]};
                8'h01: r = ln[7:0];
                8'h02: r = LINE_CRC[15:8];
                8'h03: r = LINE_CRC[7:0];
                default: r = PIXEL_BYTE;
            endcase
        end
        return r;
    endfunction

    assign next_byte = pick(nbyte, disc_d, line_d);

    // Packet framing, advanced only by master falling edges with select low
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            bit_q <= 3'h0;
            byte_q <= BYTE_ZERO;
            shift_q <= RST_SHIFT;
            discard_q <= 1'b1;
            line_q <= LINE_ZERO;
            started_q <= 1'b0;
            take_q <= 1'b0;
        end else begin
            take_q <= 1'b0;
            if (!cs_act) begin
                bit_q <= 3'h0;
                byte_q <= BYTE_ZERO;
                started_q <= 1'b0;
                shift_q <= pick(BYTE_ZERO, discard_q, line_q);
            end else if (sck_fall) begin
                if (!started_q) begin
                    started_q <= 1'b1;
                end else begin
                    bit_q <= bit_q + 3'h1;
                    if (bit_q == BIT_LAST) begin
                        byte_q <= nbyte;
                        shift_q <= next_byte;
                    end else begin
                        shift_q <= {shift_q[6:0], 1'b0};
                    end
                    if (end_pkt) begin
                        discard_q <= disc_d;
                        line_q <= line_d;
                        take_q <= discard_q & ~disc_d;
                    end
                end
            end
        end
    end

    // Data comes out MSB first with no framing strobes beside it
    assign MISO = shift_q[7];
    assign MISO_OE_N = ~cs_act;
    assign FRAME_TAKE = take_q;
    assign LINE_NUM = line_q;
    assign BYTE_IDX = nbyte;

    a_cs_restart: assert property (@(posedge CLOCK) disable iff (RST)
        !cs_act |=> (byte_q == BYTE_ZERO && bit_q == 3'h0))
        else $error("packet not restarted on select release");

    a_idle_hold: assert property (@(posedge CLOCK) disable iff (RST)
        (cs_act && started_q && !sck_fall) |=> $stable(shift_q))
        else $error("data moved without a falling edge");

    a_pkt_len: assert property (@(posedge CLOCK) disable iff (RST)
        (cs_act && sck_fall && started_q && end_pkt) |=>
        (byte_q == BYTE_ZERO))
        else $error("packet length wrong");

    a_discard_id: assert property (@(posedge CLOCK) disable iff (RST)
        (discard_q && byte_q == BYTE_ZERO && cs_act && started_q)
        |-> shift_q[7:4] == 4'h0 || bit_q != 3'h0)
        else $error("discard id nibble wrong");

    a_take_ready: assert property (@(posedge CLOCK) disable iff (RST)
        $rose(take_q) |-> $past(FRAME_READY) && !discard_q)
        else $error("frame taken without ready");

    a_stay_discard: assert property (@(posedge CLOCK) disable iff (RST)
        (discard_q && !FRAME_READY) |=> discard_q)
        else $error("left discard without a frame");

    a_oe_select: assert property (@(posedge CLOCK) disable iff (RST)
        MISO_OE_N == cs_sync_q[1])
        else $error("drive not tied to select");

    a_line_wrap: assert property (@(posedge CLOCK) disable iff (RST)
        (line_q != LINE_ZERO) |-> !discard_q)
        else $error("line count in discard");

    // A discard packet ends while a frame waits
    sequence s_frame_start;
        cs_act && sck_fall && started_q && end_pkt && discard_q && FRAME_READY;
    endsequence

    // The last line of a frame ends
    sequence s_frame_end;
        cs_act && sck_fall && started_q && end_pkt && !discard_q &&
        line_q == 12'(LINES - 1);
    endsequence

    a_frame_start: assert property (@(posedge CLOCK) disable iff (RST)
        s_frame_start |=> (take_q && !discard_q && shift_q == 8'h00))
        else $error("frame did not start with line zero id");

    a_frame_end: assert property (@(posedge CLOCK) disable iff (RST)
        s_frame_end |=> (discard_q && shift_q == {4'h0, DISCARD_NIBBLE}))
        else $error("discard id missing after frame");

    a_arm_first: assert property (@(posedge CLOCK) disable iff (RST)
        (cs_act && !started_q && sck_fall) |=> (started_q && bit_q == 3'h0))
        else $error("first falling edge moved data");

    a_rise_hold: assert property (@(posedge CLOCK) disable iff (RST)
        (cs_act && sck_rise) |=> $stable(shift_q))
        else $error("data moved on a rising edge");

    a_take_pulse: assert property (@(posedge CLOCK) disable iff (RST)
        take_q |=> !take_q)
        else $error("frame take longer than one cycle");
endmodule // vsc_slave

// ==== verif/vsc_host.sv ====
// Host master model pulling bytes over the mode 3 link
`timescale 1ns/1ps
module vsc_host (
    // Link pins
    output logic sck,
    output logic cs_n,
    input wire logic miso
);
    int half = 200;
    initial sck = 1'b1;
    initial cs_n = 1'b1;
    // The host waits for nothing and acknowledges nothing
    task automatic sel(input logic on);
        #(half + 13) cs_n = ~on;
        #(4 * half);
    endtask
    // Sample just before the middle of the high phase, clear of the slave's sync delay
    task automatic get_byte(output logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            #(half) sck = 1'b0;
            #(half) sck = 1'b1;
            #(half - 10) b[i] = miso;
            #10;
        end
    endtask
endmodule // vsc_host

// ==== verif/tb.sv ====
// Testbench for the video serial channel slave
`timescale 1ns/1ps
module tb;
    import vsc_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic ready = 1'b0;
    logic took = 1'b0;
    logic [15:0] crc = 16'hA000;
    vsc_fmt_e fmt = FMT_RAW14;
    logic sck, cs_n, miso, oe_n, take;
    logic [11:0] ln;
    logic [7:0] idx;
    int n_fail = 0;
    int checks_done = 0;
    always #25 clock = ~clock;
    // Released line shows the inverse of the slave's register
    vsc_host host (.sck(sck), .cs_n(cs_n), .miso(oe_n ? ~miso : miso));
    vsc_slave #(.LINES(1)) DUT (.CLOCK(clock), .RST(rst), .SCK(sck),
        .CS_N(cs_n), .MISO(miso), .MISO_OE_N(oe_n), .FORMAT(fmt),
        .FRAME_READY(ready), .FRAME_TAKE(take), .LINE_NUM(ln),
        .BYTE_IDX(idx), .PIXEL_BYTE(idx), .LINE_CRC(crc));
    always @(posedge clock) if (take === 1'b1) begin
        ready <= 1'b0;
        took <= 1'b1;
    end
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] eb(input int k, input logic v);
        if (!v) return (k == 0) ? 8'h0F : 8'h00;
        return (k == 2) ? crc[15:8] : (k == 3) ? crc[7:0] :
            (k < 2) ? 8'h00 : 8'(k);
    endfunction
    task automatic pkt(input int k0, input int n, input logic v);
        logic [7:0] b;
        for (int k = k0; k < k0 + n; k++) begin
            host.get_byte(b);
            cmp8(b, eb(k, v));
        end
    endtask
    task automatic do_reset(input vsc_fmt_e f);
        @(posedge clock) rst <= 1'b1;
        fmt <= f;
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        repeat (4) @(posedge clock);
    endtask
    task automatic t_stream;
        @(posedge clock) crc <= 16'hA05C;
        host.sel(1'b1);
        pkt(0, 100, 1'b0);
        @(posedge clock) ready <= 1'b1;
        pkt(100, RAW_PKT_BYTES - 100, 1'b0);
        pkt(0, RAW_PKT_BYTES, 1'b1);
        cmp8({7'h0, took}, 8'h01);
        pkt(0, 2, 1'b0);
    endtask
    task automatic t_restart;
        host.half = 1000;
        pkt(2, 3, 1'b0);
        host.sel(1'b0);
        cmp8({7'h0, oe_n}, 8'h01);
        host.sel(1'b1);
        cmp8({7'h0, oe_n}, 8'h00);
        pkt(0, 2, 1'b0);
        host.sel(1'b0);
        host.half = 200;
    endtask
    task automatic t_rgb;
        do_reset(FMT_RGB888);
        host.sel(1'b1);
        pkt(0, RGB_PKT_BYTES, 1'b0);
        pkt(0, 1, 1'b0);
        host.sel(1'b0);
    endtask
    task automatic end_sim;
        $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #4ms;
        n_fail++;
        end_sim();
    end
    initial begin
        do_reset(FMT_RAW14);
        t_stream();
        t_restart();
        t_rgb();
        end_sim();
    end
endmodule // tb
